// [hdl/trace_trigger_params.svh]
// Constants of the bus trace trigger and capture core.
// Summary of operation
// - After trigger, count delay cycles, then freeze.
// - Unfiltered window holds 170 bus cycles.
// - Sample is 48 channels in byte fields.
// - Filtered mode stores only matching cycles.
// - Filtered runs until full, reports free entries.
// - Host stop halts recording, keeps entries readable.
// - Filtered recording waits for qualifier if enabled.
`ifndef TRACE_TRIGGER_PARAMS_SVH
`define TRACE_TRIGGER_PARAMS_SVH
`define TT_DEPTH          8'hAA
`define TT_NFIELD         6
`define TT_PRESET_BOTTOM  16'h0004
`define TT_PRESET_MIDDLE  16'h0055
`define TT_PRESET_TOP     16'h00A5
`define TT_REG_CTRL       8'h00
`define TT_REG_DELAY      8'h04
`define TT_REG_TABLE      8'h08
`define TT_REG_QUAL       8'h0C
`define TT_REG_STATUS     8'h10
`define TT_REG_RDPTR      8'h14
`define TT_REG_DLO        8'h18
`define TT_REG_DHI        8'h1C
`define TT_CTRL_ARM       0
`define TT_CTRL_STOP      1
`define TT_CTRL_FILTER    2
`define TT_CTRL_QUALEN    3
`define TT_CTRL_CLEAR     4
`define TT_CTRL_FILL      5
`define TT_DELAY_RESET    16'h0004
`endif

// [hdl/trace_trigger_pkg.sv]
// Types of the bus trace trigger and capture core.
package trace_trigger_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_QUAL, ST_PRE, ST_DELAY, ST_FROZEN
  } cap_state_t;
  typedef logic [47:0] sample_t;
endpackage : trace_trigger_pkg

// [hdl/table_if.sv]
// Interface carrying truth table writes and the match result.
`timescale 1ns/100ps
`default_nettype none
interface table_if;
  logic        wr;
  logic [2:0]  field;
  logic [7:0]  index;
  logic        value;
  logic        clear;
  logic        fill;
  logic        qual_sel;
  logic [47:0] sample;
  logic        trig_hit;
  logic        qual_hit;
  modport ctrl (output wr, field, index, value, clear, fill, qual_sel, sample,
                input trig_hit, qual_hit);
  modport tbl  (input wr, field, index, value, clear, fill, qual_sel, sample,
                output trig_hit, qual_hit);
endinterface : table_if
`default_nettype wire

// [hdl/truth_tables.sv]
// Per-field truth tables for trigger and qualifier matching.
`timescale 1ns/100ps
`default_nettype none
`include "trace_trigger_params.svh"
module truth_tables (
  input wire logic clk,
  input wire logic rst_n,
  table_if.tbl     tif
);
  logic [255:0] trig_ff [`TT_NFIELD];
  logic [255:0] qual_ff [`TT_NFIELD];
  logic [`TT_NFIELD-1:0] trig_bit;
  logic [`TT_NFIELD-1:0] qual_bit;

  genvar g;
  generate
    for (g = 0; g < `TT_NFIELD; g++) begin : g_field
      wire [7:0] fval = tif.sample[8*g +: 8];
      wire       sel  = tif.wr && (tif.field == 3'(g));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          trig_ff[g] <= '0;
          qual_ff[g] <= '0;
        end else if (tif.clear) begin
          trig_ff[g] <= tif.fill ? '1 : '0;
          qual_ff[g] <= tif.fill ? '1 : '0;
        end else if (sel && !tif.qual_sel) begin
          trig_ff[g][tif.index] <= tif.value;
        end else if (sel) begin
          qual_ff[g][tif.index] <= tif.value;
        end
      end
      assign trig_bit[g] = trig_ff[g][fval];
      assign qual_bit[g] = qual_ff[g][fval];
    end
  endgenerate

  assign tif.trig_hit = &trig_bit;
  assign tif.qual_hit = &qual_bit;
endmodule : truth_tables
`default_nettype wire

// [hdl/bus_trace_trigger_capture.sv]
// Top of the bus trace trigger and capture core with AXI4-Lite registers.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "trace_trigger_params.svh"
module bus_trace_trigger_capture (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        bus_cycle,
  input  wire logic [47:0] bus_sample,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // --------------------------------------------------------------
  // Reset release.
  // --------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_ff <= 2'h0;
    else         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  wire rst_n = rst_sync_ff[1];

  // --------------------------------------------------------------
  // AXI4-Lite write path.
  // --------------------------------------------------------------
  logic        aw_got_ff, w_got_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        ctrl_filter_ff, ctrl_qualen_ff;
  logic [15:0] delay_cfg_ff;
  logic [7:0]  rdptr_ff;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_got_ff && w_got_ff && !s_axi_bvalid;
  wire full_w  = &wstrb_ff;
  wire wr_ctrl  = wr_go && (awaddr_ff == `TT_REG_CTRL);
  wire wr_delay = wr_go && (awaddr_ff == `TT_REG_DELAY);
  wire wr_table = wr_go && (awaddr_ff == `TT_REG_TABLE);
  wire wr_qual  = wr_go && (awaddr_ff == `TT_REG_QUAL);
  wire wr_rdptr = wr_go && (awaddr_ff == `TT_REG_RDPTR);
  wire wr_known = wr_ctrl || wr_delay || wr_table || wr_qual || wr_rdptr;
  wire do_arm   = wr_ctrl && wdata_ff[`TT_CTRL_ARM];
  wire do_stop  = wr_ctrl && wdata_ff[`TT_CTRL_STOP];
  wire do_clear = wr_ctrl && wdata_ff[`TT_CTRL_CLEAR];
  wire aw_got_nxt   = !wr_go && (aw_got_ff || aw_take);
  wire w_got_nxt    = !wr_go && (w_got_ff || w_take);
  wire ctrl_wr_full = wr_ctrl && full_w;
  wire filter_now   = ctrl_wr_full ? wdata_ff[`TT_CTRL_FILTER] : ctrl_filter_ff;
  wire qualen_now   = ctrl_wr_full ? wdata_ff[`TT_CTRL_QUALEN] : ctrl_qualen_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff      <= 1'b0;
      w_got_ff       <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      wstrb_ff       <= 4'h0;
      awaddr_ff      <= 8'h00;
      wdata_ff       <= 32'h0000_0000;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= 2'h0;
      ctrl_filter_ff <= 1'b0;
      ctrl_qualen_ff <= 1'b0;
      delay_cfg_ff   <= `TT_DELAY_RESET;
      rdptr_ff       <= 8'h00;
    end else begin
      s_axi_awready <= !aw_got_nxt;
      s_axi_wready  <= !w_got_nxt;
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl && full_w) begin
        ctrl_filter_ff <= wdata_ff[`TT_CTRL_FILTER];
        ctrl_qualen_ff <= wdata_ff[`TT_CTRL_QUALEN];
      end
      if (wr_delay && full_w) delay_cfg_ff <= wdata_ff[15:0];
      if (wr_rdptr && full_w) rdptr_ff <= wdata_ff[7:0];
    end
  end

  // --------------------------------------------------------------
  // Truth tables.
  // --------------------------------------------------------------
  table_if tif ();
  assign tif.wr       = (wr_table || wr_qual) && full_w;
  assign tif.qual_sel = wr_qual;
  assign tif.field    = wdata_ff[10:8];
  assign tif.index    = wdata_ff[7:0];
  assign tif.value    = wdata_ff[16];
  assign tif.clear    = do_clear;
  assign tif.fill     = wdata_ff[`TT_CTRL_FILL];
  assign tif.sample   = bus_sample;
  truth_tables u_tables (
    .clk   (clk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // --------------------------------------------------------------
  // Capture engine.
  // --------------------------------------------------------------
  trace_trigger_pkg::cap_state_t state_ff, nxt_state;
  logic [47:0] buf_mem [`TT_DEPTH];
  logic [7:0]  wptr_ff, count_ff;
  logic [15:0] dly_ff;
  logic        triggered_ff;
  wire in_run   = (state_ff == trace_trigger_pkg::ST_PRE) ||
                  (state_ff == trace_trigger_pkg::ST_DELAY);
  wire buf_full = (count_ff == `TT_DEPTH);
  wire rec = bus_cycle && in_run && !do_stop &&
             (!ctrl_filter_ff || (tif.trig_hit && !buf_full));
  wire [7:0] wptr_inc = (wptr_ff == `TT_DEPTH - 8'h01) ? 8'h00 : wptr_ff + 8'h01;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      trace_trigger_pkg::ST_IDLE, trace_trigger_pkg::ST_FROZEN: begin
        if (do_arm) begin
          if (filter_now && qualen_now)         nxt_state = trace_trigger_pkg::ST_WAIT_QUAL;
          else                                  nxt_state = trace_trigger_pkg::ST_PRE;
        end
      end
      trace_trigger_pkg::ST_WAIT_QUAL: begin
        if (bus_cycle && tif.qual_hit) nxt_state = trace_trigger_pkg::ST_PRE;
      end
      trace_trigger_pkg::ST_PRE: begin
        if (ctrl_filter_ff) begin
          if (rec && count_ff == `TT_DEPTH - 8'h01) nxt_state = trace_trigger_pkg::ST_FROZEN;
        end else if (bus_cycle && tif.trig_hit) begin
          nxt_state = (delay_cfg_ff == 16'h0000) ? trace_trigger_pkg::ST_FROZEN
                                                 : trace_trigger_pkg::ST_DELAY;
        end
      end
      trace_trigger_pkg::ST_DELAY: begin
        if (bus_cycle && dly_ff == 16'h0001) nxt_state = trace_trigger_pkg::ST_FROZEN;
      end
      default: nxt_state = trace_trigger_pkg::ST_IDLE;
    endcase
    if (do_stop && state_ff != trace_trigger_pkg::ST_IDLE) begin
      nxt_state = trace_trigger_pkg::ST_FROZEN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= trace_trigger_pkg::ST_IDLE;
      wptr_ff      <= 8'h00;
      count_ff     <= 8'h00;
      dly_ff       <= 16'h0000;
      triggered_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (do_arm && !in_run) begin
        wptr_ff      <= 8'h00;
        count_ff     <= 8'h00;
        triggered_ff <= 1'b0;
        dly_ff       <= delay_cfg_ff;
      end else begin
        if (rec) begin
          wptr_ff <= wptr_inc;
          if (!buf_full) count_ff <= count_ff + 8'h01;
        end
        if (state_ff == trace_trigger_pkg::ST_PRE && !ctrl_filter_ff && bus_cycle &&
            tif.trig_hit) triggered_ff <= 1'b1;
        if (state_ff == trace_trigger_pkg::ST_DELAY && bus_cycle) dly_ff <= dly_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rec) buf_mem[wptr_ff] <= bus_sample;
  end

  // --------------------------------------------------------------
  // AXI4-Lite read path.
  // --------------------------------------------------------------
  wire [7:0]  ra    = {s_axi_araddr[7:2], 2'b00};
  wire [7:0]  free  = `TT_DEPTH - count_ff;
  wire [47:0] entry = buf_mem[rdptr_ff];
  wire [31:0] rd_val;
  assign rd_val =
    (ra == `TT_REG_CTRL)   ? {28'h0, ctrl_qualen_ff, ctrl_filter_ff, 2'h0} :
    (ra == `TT_REG_DELAY)  ? {16'h0000, delay_cfg_ff} :
    (ra == `TT_REG_STATUS) ? {8'h00, free, count_ff, triggered_ff, 4'h0, 3'(state_ff)} :
    (ra == `TT_REG_RDPTR)  ? {16'h0000, wptr_ff, rdptr_ff} :
    (ra == `TT_REG_DLO)    ? entry[31:0] :
    (ra == `TT_REG_DHI)    ? {16'h0000, entry[47:32]} : 32'h0000_0000;
  wire rd_ok = (ra == `TT_REG_CTRL) || (ra == `TT_REG_DELAY) || (ra == `TT_REG_STATUS) ||
               (ra == `TT_REG_RDPTR) || (ra == `TT_REG_DLO) || (ra == `TT_REG_DHI);
  wire ar_take    = s_axi_arvalid && s_axi_arready;
  wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_arready <= !rvalid_nxt;
      if (ar_take) begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end
    end
  end
endmodule : bus_trace_trigger_capture
`default_nettype wire

// [test/bus_target_model.sv]
// Target bus model issuing one bus cycle per clock while running.
`timescale 1ns/100ps
`default_nettype none
module bus_target_model (
  input  wire logic        clk,
  input  wire logic        run,
  output logic             bus_cycle,
  output logic [47:0]      bus_sample
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk) begin
    cnt_ff <= run ? cnt_ff + 8'h01 : 8'h00;
  end
  // Each field carries the cycle number; idle lines show the inverse.
  assign bus_cycle  = run;
  assign bus_sample = run ? {6{cnt_ff}} : {6{~cnt_ff}};
endmodule : bus_target_model
`default_nettype wire

// [test/bus_trace_trigger_capture_assertions.sv]
// Register bus assertions of the trace trigger capture core.
`timescale 1ns/100ps
`default_nettype none
module bus_trace_trigger_capture_assertions (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  a_aw_held: assert property (s_aw |=> !s_axi_awready) else $error("awready after take");
  a_w_held: assert property (s_w |=> !s_axi_wready) else $error("wready after take");
  a_write_answer: assert property ((s_aw and s_w) |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_read_answer: assert property (s_ar |=> s_axi_rvalid) else $error("no read data");
  a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("error read not zero");
endmodule : bus_trace_trigger_capture_assertions
bind bus_trace_trigger_capture bus_trace_trigger_capture_assertions chk_i (
  .clk           (clk),
  .arst_n        (arst_n),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp)
);
`default_nettype wire

// [test/bus_trace_trigger_capture_tb_top.sv]
// Self-checking bench of the trace trigger capture core.
`timescale 1ns/100ps
`default_nettype none
`include "trace_trigger_params.svh"
module bus_trace_trigger_capture_tb_top;
  logic        clk = 1'b0, arst_n = 1'b0, run = 1'b0, bus_cycle;
  logic [47:0] bus_sample, e;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, bq;
  int          err_total = 0, check_count = 0, cyc = 0, wp;
  always #50 clk = ~clk;
  bus_target_model tgt (.clk(clk), .run(run), .bus_cycle(bus_cycle), .bus_sample(bus_sample));
  bus_trace_trigger_capture dut (
    .clk           (clk),
    .arst_n        (arst_n),
    .bus_cycle     (bus_cycle),
    .bus_sample    (bus_sample),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      bq = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic hr, hv;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      hr = s_axi_arvalid && s_axi_arready;
      hv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (hr) s_axi_arvalid <= 1'b0;
    end while (!hv);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic ent(input int i);
    wr(`TT_REG_RDPTR, i);
    rd(`TT_REG_DLO);
    e[31:0] = d;
    rd(`TT_REG_DHI);
    e[47:32] = d[15:0];
  endtask : ent
  task automatic go(input int n);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask : go
  task automatic tab(input logic [7:0] ra, input logic [7:0] idx);
    for (int f = 0; f < 6; f++) begin
      wr(ra, {15'h0000, 1'b1, 5'h00, 3'(f), idx});
    end
  endtask : tab
  task automatic t_reset;
    rd(`TT_REG_DELAY);
    chk(d, `TT_DELAY_RESET);
    s_axi_wstrb <= 4'h3;
    wr(`TT_REG_DELAY, 32'h0000_0055);
    chk(bq, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(`TT_REG_DELAY);
    chk(d, `TT_DELAY_RESET);
    wr(8'h20, 32'h0000_0001);
    chk(bq, 2'h2);
    rd(8'h20);
    chk(r, 2'h2);
    chk(d, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_trig(input logic [15:0] dl);
    wr(`TT_REG_CTRL, 32'h10);
    wr(`TT_REG_DELAY, {16'h0000, dl});
    tab(`TT_REG_TABLE, 8'hC8);
    wr(`TT_REG_CTRL, 32'h1);
    go(400);
    rd(`TT_REG_STATUS);
    chk(d[7:0], 8'h84);
    rd(`TT_REG_RDPTR);
    wp = int'(d[15:8]);
    ent((wp + 169) % 170);
    chk(e, {6{8'hC8 + dl[7:0]}});
    ent((wp + 169 - int'(dl)) % 170);
    chk(e, {6{8'hC8}});
    ent(wp);
    chk(e, {6{8'hC8 + dl[7:0] - 8'hA9}});
    $display("test trigger delay done");
  endtask : t_trig
  task automatic t_filter;
    wr(`TT_REG_CTRL, 32'h10);
    for (int i = 0; i < 256; i += 3) tab(`TT_REG_TABLE, 8'(i));
    tab(`TT_REG_QUAL, 8'h10);
    wr(`TT_REG_CTRL, 32'h5);
    go(30);
    wr(`TT_REG_CTRL, 32'h6);
    go(20);
    rd(`TT_REG_STATUS);
    chk(d[23:16], 8'hA0);
    chk(d[15:8], 8'h0A);
    ent(9);
    chk(e, {6{8'h1B}});
    wr(`TT_REG_CTRL, 32'h5);
    go(520);
    rd(`TT_REG_STATUS);
    chk(d[23:16], 8'h00);
    chk(d[2:0], 3'h4);
    ent(100);
    chk(e, {6{8'h2A}});
    wr(`TT_REG_CTRL, 32'hD);
    go(30);
    wr(`TT_REG_CTRL, 32'hE);
    rd(`TT_REG_STATUS);
    chk(d[23:16], 8'hA6);
    ent(0);
    chk(e, {6{8'h12}});
    rd(`TT_REG_CTRL);
    chk(d, 32'h0000_000C);
    $display("test filter done");
  endtask : t_filter
  task automatic t_next;
    wr(`TT_REG_DELAY, {16'h0000, (`TT_PRESET_BOTTOM + 16'h00AA)});
    wr(`TT_REG_CTRL, 32'h1);
    go(400);
    rd(`TT_REG_RDPTR);
    wp = int'(d[15:8]);
    ent(wp);
    chk(e, {6{8'hCD}});
    ent((wp + 169) % 170);
    chk(e, {6{8'h76}});
    $display("test next window done");
  endtask : t_next
  task automatic t_not;
    wr(`TT_REG_CTRL, 32'h30);
    for (int v = 0; v < 10; v++) wr(`TT_REG_TABLE, {24'h000000, 8'(v)});
    wr(`TT_REG_DELAY, {16'h0000, `TT_PRESET_BOTTOM});
    run <= 1'b1;
    wr(`TT_REG_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    run <= 1'b0;
    rd(`TT_REG_STATUS);
    chk(d[7:0], 8'h84);
    rd(`TT_REG_RDPTR);
    wp = int'(d[15:8]);
    ent((wp + 169) % 170);
    chk(e, {6{8'h0E}});
    ent((wp + 165) % 170);
    chk(e, {6{8'h0A}});
    ent((wp + 164) % 170);
    chk(e, {6{8'h09}});
    $display("test negated snapshot done");
  endtask : t_not
  task automatic t_midrst;
    wr(`TT_REG_DELAY, 32'h0000_0055);
    wr(`TT_REG_CTRL, 32'h1);
    run <= 1'b1;
    repeat (5) @(posedge clk);
    arst_n <= 1'b0;
    run <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TT_REG_STATUS);
    chk(d[23:0], 24'hAA0000);
    rd(`TT_REG_DELAY);
    chk(d, `TT_DELAY_RESET);
    $display("test mid-run reset done");
  endtask : t_midrst
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_trig(`TT_PRESET_BOTTOM);
    t_next;
    t_trig(`TT_PRESET_MIDDLE);
    t_trig(`TT_PRESET_TOP);
    t_not;
    t_filter;
    t_midrst;
    tally_and_finish;
  end
endmodule : bus_trace_trigger_capture_tb_top
`default_nettype wire
